//--- design/fault_supervisor_map.vh
/*
 * Register map, field positions, reset values and timing figures of the
 * fault supervisor. Assumes a 200 MHz reference clock.
 */
`ifndef FAULT_SUPERVISOR_MAP_VH
`define FAULT_SUPERVISOR_MAP_VH

`define FSW_A_CTRL 6'h00
`define FSW_A_POLICY 6'h01
`define FSW_A_SERVICE 6'h02
`define FSW_A_DIAG0 6'h03
`define FSW_A_DIAG1 6'h04
`define FSW_A_STATUS 6'h05

`define FSW_F_GAIN 1:0
`define FSW_F_OFFSET 2
`define FSW_F_OCLVL 4:3
`define FSW_F_BLANK 8:5
`define FSW_F_THSEL 9
`define FSW_F_MON 12:10
`define FSW_F_WIN 15:13
`define FSW_F_IRQPOL 16
`define FSW_F_LATOC 17
`define FSW_F_LATFS 18
`define FSW_CTRL_W 19

`define FSW_P_SUV 1:0
`define FSW_P_SOV 3:2
`define FSW_P_MOV 5:4
`define FSW_P_GUV 7:6
`define FSW_P_OC 9:8
`define FSW_P_FS 11:10
`define FSW_P_TW 13:12
`define FSW_P_TS 15:14
`define FSW_P_WD 17:16
`define FSW_POL_W 18

`define FSW_CTRL_RST 19'h00000
`define FSW_POL_RST 18'h2AAAA
`define FSW_CLEAR_CODE 8'hFF

`define FSW_CLK_MHZ 200
`define FSW_TBLANK_NS 200
`define FSW_TFOW_US 409600
`define FSW_TCW_US 102400
`define FSW_TWT_US 204800
`define FSW_TMR_US 400
`define FSW_TREC_US 10

`endif

//--- design/sync_two_ff.v
/*
 * Two flip-flop synchroniser for a group of unrelated level inputs.
 * Assumes each bit is a slow level; no bus coherence between bits.
 */
`timescale 1ns/1ps
module sync_two_ff #(
    parameter WIDTH = 1
) (
    input wire ref_clk, // Reference clock
    input wire sys_rst, // Synchronous reset, active high
    input wire [WIDTH-1:0] d, // Asynchronous levels
    output wire [WIDTH-1:0] q // Synchronised levels
);
    reg [WIDTH-1:0] meta_ff;
    reg [WIDTH-1:0] sync_ff;

    always @(posedge ref_clk) begin
        if (sys_rst) begin
            meta_ff <= {WIDTH{1'b0}};
            sync_ff <= {WIDTH{1'b0}};
        end else begin
            meta_ff <= d;
            sync_ff <= meta_ff;
        end
    end

    assign q = sync_ff;
endmodule // sync_two_ff

//--- design/window_watchdog.v
/*
 * Window watchdog: first open window, then closed and open windows
 * after each service. Assumes service is a one-cycle pulse.
 */
`timescale 1ns/1ps
module window_watchdog #(
    parameter FOW_CYC = 81920000,
    parameter CW_CYC = 20480000,
    parameter WT_CYC = 40960000
) (
    input wire ref_clk, // Reference clock
    input wire sys_rst, // Synchronous reset, active high
    input wire enable, // Supervision active
    input wire [2:0] windowSel, // Window length code
    input wire service, // Service write pulse
    output wire wdError // Error pulse, one cycle
);
    localparam S_FIRST = 2'd0;
    localparam S_CLOSED = 2'd1;
    localparam S_OPEN = 2'd2;

    reg [1:0] state_ff;
    reg [31:0] cnt_ff;
    reg err_ff;
    wire [31:0] fowLim = FOW_CYC >> windowSel;
    wire [31:0] cwLim = CW_CYC >> windowSel;
    wire [31:0] wtLim = WT_CYC >> windowSel;
    wire [31:0] cntInc = cnt_ff + 32'h00000001;

    always @(posedge ref_clk) begin
        if (sys_rst || !enable) begin
            state_ff <= S_FIRST;
            cnt_ff <= 32'h00000000;
            err_ff <= 1'b0;
        end else begin
            err_ff <= 1'b0;
            cnt_ff <= cntInc;
            case (state_ff)
                S_CLOSED: begin
                    if (service) begin
                        err_ff <= 1'b1;
                        state_ff <= S_FIRST;
                        cnt_ff <= 32'h00000000;
                    end else if (cntInc >= cwLim) begin
                        state_ff <= S_OPEN;
                        cnt_ff <= 32'h00000000;
                    end
                end
                S_FIRST, S_OPEN: begin
                    if (service) begin
                        state_ff <= S_CLOSED;
                        cnt_ff <= 32'h00000000;
                    end else if (cntInc >= ((state_ff == S_FIRST) ?
                                            fowLim : wtLim)) begin
                        err_ff <= 1'b1;
                        state_ff <= S_FIRST;
                        cnt_ff <= 32'h00000000;
                    end
                end
                default: begin
                    state_ff <= S_FIRST;
                    cnt_ff <= 32'h00000000;
                end
            endcase
        end
    end

    assign wdError = err_ff;
endmodule // window_watchdog

//--- design/fault_supervisor_watchdog.v
/*
 * Protection supervisor of a gate pre-driver: over-current blanking,
 * thermal and supply reactions, window watchdog, response policies,
 * diagnostic flags and interrupt, all on an AHB-Lite register slave.
 * Assumes comparator results arrive asynchronously as digital levels.
 */
// Function
// - Over-current trips above selected shunt threshold
// - Unmasked over-current puts all drivers Hi-Z
// - Blank comparator 0.2 to 3.2 us after switching
// - Thermal select picks warning and shutoff limits
// - Thermal shutoff kills supplies, drivers, reset, serial
// - Monitor select routes analog output or Hi-Z
// - Sense gain selectable, rewritable any time
// - Offset select picks unidirectional or bidirectional
// - Open-window service restarts watchdog sequence
// - Closed-window service or timeout is error
// - First open window 409.6 ms, halving
// - Closed window 102.4 ms, halving per code
// - Host reset pulse held low 400 us
// - First diagnostic register kept until read
// - All faults flag and summarise in status
// - Reportable faults drive interrupt, polarity selectable
// - Latched faults hold until enable low or FFh
// - Voltage and current faults off in auto/latch
// - Regulator undervoltage: drivers off, host reset low
// - Current faults only with enable; clear per policy
// - Thermal and watchdog ignore on, auto off
// - Watchdog active only while host reset high
// - Watchdog auto-recover gives reset low pulse
// - Thermal auto-recover drives host reset low
// - Enable low forces every driver off
`timescale 1ns/1ps
`include "fault_supervisor_map.vh"
module fault_supervisor_watchdog #(
    parameter FOW_CYC = `FSW_TFOW_US * `FSW_CLK_MHZ,
    parameter CW_CYC = `FSW_TCW_US * `FSW_CLK_MHZ,
    parameter WT_CYC = `FSW_TWT_US * `FSW_CLK_MHZ,
    parameter MR_CYC = `FSW_TMR_US * `FSW_CLK_MHZ,
    parameter REC_CYC = `FSW_TREC_US * `FSW_CLK_MHZ
) (
    input wire ref_clk, // Reference clock, 200 MHz
    input wire sys_rst, // Synchronous reset, active high
    input wire hsel, // AHB select
    input wire [31:0] haddr, // AHB address
    input wire [1:0] htrans, // AHB transfer type
    input wire hwrite, // AHB write
    input wire [2:0] hsize, // AHB size
    input wire [31:0] hwdata, // AHB write data
    input wire hready, // AHB ready in
    output wire hreadyout, // AHB ready out
    output wire hresp, // AHB response
    output wire [31:0] hrdata, // AHB read data
    input wire ocCmp, // Shunt above threshold
    input wire fetShortCmp, // FET drain-source short
    input wire supplyUvCmp, // Supply undervoltage
    input wire supplyOvCmp, // Supply overvoltage
    input wire motorOvCmp, // Motor supply overvoltage
    input wire gateUvCmp, // Gate supply undervoltage
    input wire regUvCmp, // External regulator low
    input wire tempWarnCmp, // Temperature above warning
    input wire tempShutCmp, // Temperature above shutoff
    input wire switchEvt, // Gate switching in progress
    input wire driveEn, // Drive enable pin
    output wire [1:0] senseGainSel, // Amplifier gain code
    output wire senseOffsetSel, // 1: bidirectional offset
    output wire [1:0] overcurrentLevelSel, // Trip level code
    output wire thermalThresholdSel, // Thermal limit set
    output wire [4:0] analogMonitorRoute, // One-hot mux, 0 Hi-Z
    output wire driverHiZ, // All gate drivers Hi-Z
    output wire driverOff, // All drivers to source
    output wire gateSupplyEn, // Gate supply on
    output wire regulatorEn, // External regulator on
    output wire hostResetOutN, // Host reset, active low
    output wire spiEnable, // Serial link usable
    output wire faultIrqOut // Diagnostic interrupt
);
    localparam BLK_CYC = (`FSW_TBLANK_NS * `FSW_CLK_MHZ + 999) / 1000;
    localparam [1:0] P_IGN = 2'd0;
    localparam [1:0] P_REP = 2'd1;
    localparam [1:0] P_AUTO = 2'd2;
    localparam [1:0] P_LATCH = 2'd3;

    // Policy class: 0 all four, 1 no latch, 2 warn, 3 ignore/auto
    function [1:0] normPol;
        input [1:0] p;
        input [1:0] cls;
        begin
            case (cls)
                2'd1: normPol = (p == P_LATCH) ? P_AUTO : p;
                2'd2: normPol = (p == P_IGN) ? P_IGN : P_REP;
                2'd3: normPol = (p[1] | p[0] & p[1]) ? P_AUTO : P_IGN;
                default: normPol = p;
            endcase
        end
    endfunction

    // Monitor decode: motor, phase 1..3, temperature; else Hi-Z
    function [4:0] monRoute;
        input [2:0] s;
        begin
            case (s)
                3'd0: monRoute = 5'h01;
                3'd1: monRoute = 5'h02;
                3'd2: monRoute = 5'h04;
                3'd3: monRoute = 5'h08;
                3'd4, 3'd5: monRoute = 5'h10;
                default: monRoute = 5'h00;
            endcase
        end
    endfunction

    // Input synchronisation
    wire [10:0] inS;
    sync_two_ff #(.WIDTH(11)) u_sync (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .d({driveEn, switchEvt, tempShutCmp, tempWarnCmp, regUvCmp,
            gateUvCmp, motorOvCmp, supplyOvCmp, supplyUvCmp,
            fetShortCmp, ocCmp}),
        .q(inS)
    );
    wire ocS = inS[0];
    wire [3:0] voltS = inS[5:2];
    wire regUvS = inS[6];
    wire tWarnS = inS[7];
    wire tShutS = inS[8];
    wire swS = inS[9];
    wire enS = inS[10];

    // Configuration registers
    reg [`FSW_CTRL_W-1:0] ctrl_ff;
    reg [`FSW_POL_W-1:0] pol_ff;
    reg [6:0] diag0_ff;
    reg [2:0] diag1_ff;

    // AHB-Lite slave, zero wait states
    reg wrPend_ff;
    reg [5:0] wrIdx_ff;
    reg [31:0] hrdata_ff;
    wire addrPh = hsel & htrans[1] & hready;
    wire [5:0] aIdx = haddr[7:2];
    wire rdAcc = addrPh & ~hwrite;
    wire wrCtrl = wrPend_ff & (wrIdx_ff == `FSW_A_CTRL);
    wire wrPol = wrPend_ff & (wrIdx_ff == `FSW_A_POLICY);
    wire wrSvc = wrPend_ff & (wrIdx_ff == `FSW_A_SERVICE);
    wire clrD0 = rdAcc & (aIdx == `FSW_A_DIAG0);
    wire clrD1 = rdAcc & (aIdx == `FSW_A_DIAG1);
    wire svcFf = wrSvc & (hwdata[7:0] == `FSW_CLEAR_CODE);

    // Policies after mapping unsupported codes
    wire [1:0] pSuv = normPol(pol_ff[`FSW_P_SUV], 2'd1);
    wire [1:0] pSov = normPol(pol_ff[`FSW_P_SOV], 2'd1);
    wire [1:0] pMov = normPol(pol_ff[`FSW_P_MOV], 2'd1);
    wire [1:0] pGuv = normPol(pol_ff[`FSW_P_GUV], 2'd1);
    wire [1:0] pOc = normPol(pol_ff[`FSW_P_OC], 2'd0);
    wire [1:0] pFs = normPol(pol_ff[`FSW_P_FS], 2'd0);
    wire [1:0] pTw = normPol(pol_ff[`FSW_P_TW], 2'd2);
    wire [1:0] pTs = normPol(pol_ff[`FSW_P_TS], 2'd3);
    wire [1:0] pWd = normPol(pol_ff[`FSW_P_WD], 2'd3);

    // Over-current blanking after switching
    reg [9:0] blank_ff;
    reg swPrev_ff;
    wire swEdge = swS ^ swPrev_ff;
    wire [9:0] blankLoad =
        ({6'h00, ctrl_ff[`FSW_F_BLANK]} + 10'h001) * BLK_CYC[9:0];
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            blank_ff <= 10'h000;
            swPrev_ff <= 1'b0;
        end else begin
            swPrev_ff <= swS;
            if (swEdge)
                blank_ff <= blankLoad;
            else if (blank_ff != 10'h000)
                blank_ff <= blank_ff - 10'h001;
        end
    end

    // Current faults: index 0 over-current, 1 FET short
    wire [1:0] hit;
    assign hit[0] = ocS & enS & (blank_ff == 10'h000) & ~swEdge;
    assign hit[1] = inS[1] & enS;
    wire [1:0] curPol [0:1];
    assign curPol[0] = pOc;
    assign curPol[1] = pFs;
    wire [1:0] latEn = {ctrl_ff[`FSW_F_LATFS], ctrl_ff[`FSW_F_LATOC]};
    wire [1:0] curOff;
    wire [1:0] curLat;

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_cur
            reg off_ff;
            reg lat_ff;
            reg [23:0] rec_ff;
            wire isLat = (curPol[gi] == P_LATCH) & latEn[gi];
            wire isAuto = (curPol[gi] == P_AUTO) |
                          ((curPol[gi] == P_LATCH) & ~latEn[gi]);
            always @(posedge ref_clk) begin
                if (sys_rst || !enS) begin
                    off_ff <= 1'b0;
                    lat_ff <= 1'b0;
                    rec_ff <= 24'h000000;
                end else if (hit[gi] && isLat) begin
                    lat_ff <= 1'b1;
                end else if (hit[gi] && isAuto) begin
                    off_ff <= 1'b1;
                    rec_ff <= REC_CYC[23:0];
                end else begin
                    if (svcFf)
                        lat_ff <= 1'b0;
                    if (rec_ff != 24'h000000)
                        rec_ff <= rec_ff - 24'h000001;
                    else
                        off_ff <= 1'b0;
                end
            end
            assign curOff[gi] = off_ff | lat_ff;
            assign curLat[gi] = lat_ff;
        end
    endgenerate

    // Supply faults switch drivers off only in auto-recover
    wire [3:0] vAuto = {pGuv == P_AUTO, pMov == P_AUTO,
                        pSov == P_AUTO, pSuv == P_AUTO};
    wire vOff = |(voltS & vAuto);
    wire thOff = tShutS & (pTs == P_AUTO);

    // Watchdog and host reset pulse
    reg hostRstN_ff;
    reg [23:0] mr_ff;
    wire wdErr;
    window_watchdog #(
        .FOW_CYC(FOW_CYC),
        .CW_CYC(CW_CYC),
        .WT_CYC(WT_CYC)
    ) u_wdog (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .enable(hostRstN_ff),
        .windowSel(ctrl_ff[`FSW_F_WIN]),
        .service(wrSvc & hostRstN_ff),
        .wdError(wdErr)
    );
    wire wdAuto = pWd == P_AUTO;
    always @(posedge ref_clk) begin
        if (sys_rst)
            mr_ff <= 24'h000000;
        else if (wdErr && wdAuto)
            mr_ff <= MR_CYC[23:0];
        else if (mr_ff != 24'h000000)
            mr_ff <= mr_ff - 24'h000001;
    end
    wire pulseAct = mr_ff != 24'h000000;

    // Reaction outputs
    reg driverHiZ_ff;
    reg driverOff_ff;
    reg supplyEn_ff;
    reg spiEn_ff;
    wire nxt_hostRstN = ~(regUvS | thOff | pulseAct);
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            driverHiZ_ff <= 1'b0;
            driverOff_ff <= 1'b1;
            supplyEn_ff <= 1'b1;
            spiEn_ff <= 1'b1;
            hostRstN_ff <= 1'b1;
        end else begin
            driverHiZ_ff <= curOff[0] | thOff;
            driverOff_ff <= ~enS | curOff[1] | vOff | regUvS |
                            (pulseAct | wdErr & wdAuto);
            supplyEn_ff <= ~thOff;
            spiEn_ff <= nxt_hostRstN;
            hostRstN_ff <= nxt_hostRstN;
        end
    end

    // Diagnostic flags: set wins over clear-on-read
    wire [6:0] set0 = {hit, regUvS, voltS};
    wire [2:0] set1 = {wdErr, tShutS, tWarnS};
    wire [6:0] rep0 = {pFs != P_IGN, pOc != P_IGN, 1'b0,
                       pGuv != P_IGN, pMov != P_IGN,
                       pSov != P_IGN, pSuv != P_IGN};
    reg irq_ff;
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            diag0_ff <= 7'h00;
            diag1_ff <= 3'h0;
            irq_ff <= 1'b0;
        end else begin
            diag0_ff <= (diag0_ff & {7{~clrD0}}) | set0;
            diag1_ff <= (diag1_ff & {3{~clrD1}}) | set1;
            irq_ff <= ~ctrl_ff[`FSW_F_IRQPOL] ^
                      (|(diag0_ff & rep0) |
                       (diag1_ff[0] & (pTw == P_REP)));
        end
    end

    // Status summary
    wire [7:0] statusByte = {3'h0, |{diag0_ff, diag1_ff},
                             |curLat, 3'h0};

    // Register write and read
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            wrPend_ff <= 1'b0;
            wrIdx_ff <= 6'h00;
            hrdata_ff <= 32'h00000000;
            ctrl_ff <= `FSW_CTRL_RST;
            pol_ff <= `FSW_POL_RST;
        end else begin
            wrPend_ff <= addrPh & hwrite;
            wrIdx_ff <= aIdx;
            if (wrCtrl) begin
                ctrl_ff <= hwdata[`FSW_CTRL_W-1:0];
                if (hwdata[4:3] == 2'd3)
                    ctrl_ff[`FSW_F_OCLVL] <= 2'd2;
            end
            if (wrPol)
                pol_ff <= hwdata[`FSW_POL_W-1:0];
            if (rdAcc) begin
                case (aIdx)
                    `FSW_A_CTRL:
                        hrdata_ff <= {13'h0000, ctrl_ff};
                    `FSW_A_POLICY:
                        hrdata_ff <= {14'h0000, pol_ff};
                    `FSW_A_DIAG0:
                        hrdata_ff <= {25'h0000000, diag0_ff};
                    `FSW_A_DIAG1:
                        hrdata_ff <= {29'h00000000, diag1_ff};
                    `FSW_A_STATUS:
                        hrdata_ff <= {24'h000000, statusByte};
                    default:
                        hrdata_ff <= 32'h00000000;
                endcase
            end
        end
    end

    // Monitor route register
    reg [4:0] mon_ff;
    always @(posedge ref_clk) begin
        if (sys_rst)
            mon_ff <= 5'h01;
        else
            mon_ff <= monRoute(ctrl_ff[`FSW_F_MON]);
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_ff;
    assign senseGainSel = ctrl_ff[`FSW_F_GAIN];
    assign senseOffsetSel = ctrl_ff[`FSW_F_OFFSET];
    assign overcurrentLevelSel = ctrl_ff[`FSW_F_OCLVL];
    assign thermalThresholdSel = ctrl_ff[`FSW_F_THSEL];
    assign analogMonitorRoute = mon_ff;
    assign driverHiZ = driverHiZ_ff;
    assign driverOff = driverOff_ff;
    assign gateSupplyEn = supplyEn_ff;
    assign regulatorEn = supplyEn_ff;
    assign hostResetOutN = hostRstN_ff;
    assign spiEnable = spiEn_ff;
    assign faultIrqOut = irq_ff;
endmodule // fault_supervisor_watchdog

//--- verification/fault_supervisor_properties.sv
/* Pin-level checker of the fault supervisor.
   Assumes one clock and the synchronous active-high reset. */
`timescale 1ns/1ps
module fault_supervisor_properties #(
    parameter MR_CYC = 50
) (
    input wire ref_clk, // Clock
    input wire sys_rst, // Reset
    input wire regUvCmp, // Regulator low
    input wire tempShutCmp, // Thermal shutoff
    input wire driveEn, // Drive enable
    input wire [4:0] analogMonitorRoute, // Monitor route
    input wire driverHiZ, // Drivers Hi-Z
    input wire driverOff, // Drivers off
    input wire gateSupplyEn, // Gate supply
    input wire regulatorEn, // Regulator
    input wire hostResetOutN, // Host reset
    input wire spiEnable, // Serial usable
    input wire faultIrqOut // Interrupt
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    int lowCnt_ff;
    // Length of a host reset pulse not held by a supply or thermal fault
    always @(posedge ref_clk) begin
        if (sys_rst || hostResetOutN || regUvCmp || tempShutCmp) begin
            lowCnt_ff <= 0;
        end else begin
            lowCnt_ff <= lowCnt_ff + 1;
        end
    end
    property p_spiFollow; spiEnable == hostResetOutN; endproperty
    a_spiFollow: assert property (p_spiFollow)
        else $error("serial enable differs from host reset");
    property p_supplyOff; !gateSupplyEn |-> !regulatorEn && driverHiZ;
    endproperty
    a_supplyOff: assert property (p_supplyOff)
        else $error("supplies off without regulator off and Hi-Z");
    property p_enableOff; (!driveEn)[*5] |-> driverOff; endproperty
    a_enableOff: assert property (p_enableOff)
        else $error("drivers not off with enable low");
    property p_regLow; regUvCmp[*5] |-> driverOff && !hostResetOutN;
    endproperty
    a_regLow: assert property (p_regLow)
        else $error("regulator fault without drivers off and reset");
    property p_monRoute; $onehot0(analogMonitorRoute); endproperty
    a_monRoute: assert property (p_monRoute)
        else $error("monitor route selects more than one input");
    property p_hizCause; (!driveEn && !tempShutCmp)[*6] |-> !driverHiZ;
    endproperty
    a_hizCause: assert property (p_hizCause)
        else $error("Hi-Z held with enable low and no thermal fault");
    property p_pulseMin;
        $fell(hostResetOutN) && !regUvCmp && !tempShutCmp
            |-> (!hostResetOutN)[*8];
    endproperty
    a_pulseMin: assert property (p_pulseMin)
        else $error("host reset pulse too short");
    property p_pulseMax; lowCnt_ff <= MR_CYC + 3; endproperty
    a_pulseMax: assert property (p_pulseMax)
        else $error("host reset pulse too long");
    c_wdPulse: cover property ($fell(hostResetOutN) && !tempShutCmp);
    c_hiz: cover property ($rose(driverHiZ));
    c_irq: cover property ($changed(faultIrqOut));
endmodule // fault_supervisor_properties

bind fault_supervisor_watchdog fault_supervisor_properties #(
    .MR_CYC(MR_CYC)
) fault_supervisor_properties_inst (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .regUvCmp(regUvCmp),
    .tempShutCmp(tempShutCmp),
    .driveEn(driveEn),
    .analogMonitorRoute(analogMonitorRoute),
    .driverHiZ(driverHiZ),
    .driverOff(driverOff),
    .gateSupplyEn(gateSupplyEn),
    .regulatorEn(regulatorEn),
    .hostResetOutN(hostResetOutN),
    .spiEnable(spiEnable),
    .faultIrqOut(faultIrqOut)
);

//--- verification/host_mcu_model.sv
/* Host microcontroller model: owns the drive enable pin.
   Assumes the pin falls to its pull-down while the host is in reset. */
`timescale 1ns/1ps
module host_mcu_model (
    input wire ref_clk, // Clock
    input wire hostResetOutN, // Reset from device
    input wire wantRun, // Bench asks to drive
    output logic driveEn = 1'h0 // Drive enable pin
);
    always @(posedge ref_clk) begin
        driveEn <= wantRun && hostResetOutN;
    end
endmodule // host_mcu_model

//--- verification/fault_supervisor_watchdog_bench.sv
/* Self-checking bench of the fault supervisor with an AHB-Lite master.
   Assumes shortened window, reset-pulse and recovery parameters. */
`timescale 1ns/1ps
module fault_supervisor_watchdog_bench;
    logic ref_clk = 0, sys_rst = 1, hsel = 0, hwrite = 0, hready;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, rv;
    logic [1:0] htrans = 0, senseGainSel, overcurrentLevelSel;
    logic [2:0] hsize = 3'h2;
    logic hreadyout, hresp, senseOffsetSel, thermalThresholdSel;
    logic [4:0] analogMonitorRoute;
    logic ocCmp = 0, fetShortCmp = 0, supplyUvCmp = 0, supplyOvCmp = 0;
    logic motorOvCmp = 0, gateUvCmp = 0, regUvCmp = 0, tempWarnCmp = 0;
    logic tempShutCmp = 0, switchEvt = 0, driveEn, wantRun = 0;
    logic driverHiZ, driverOff, gateSupplyEn, regulatorEn;
    logic hostResetOutN, spiEnable, faultIrqOut;
    logic [4:0] rt [8] = '{5'h01, 5'h02, 5'h04, 5'h08, 5'h10, 5'h10,
        5'h00, 5'h00};
    wire [3:0] tsdView = {driverHiZ, gateSupplyEn, regulatorEn,
        hostResetOutN};
    int n_fail = 0, tests_run = 0, gap, pulseLen;
    assign hready = hreadyout;
    fault_supervisor_watchdog #(
        .FOW_CYC(800), .CW_CYC(200), .WT_CYC(400), .MR_CYC(50), .REC_CYC(20)
    ) fault_supervisor_watchdog_inst (.*);
    host_mcu_model host_mcu_model_inst (.*);
    initial begin
        forever #2.5 ref_clk = ~ref_clk;
    end
    task automatic results;
        if (n_fail == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(string nm, logic [31:0] ex, logic [31:0] got);
        tests_run++;
        if (got !== ex) begin
            $display("[FAIL] %s exp %h got %h", nm, ex, got);
            n_fail++;
        end
    endtask
    task automatic cyc(int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic waitRdy;
        int k = 0;
        do begin
            @(posedge ref_clk);
            k++;
        end while (hready !== 1'h1 && k < 20);
        if (k >= 20) begin
            n_fail++;
            results;
        end
    endtask
    task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
        hsel <= 1'h1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        hsize <= 3'h2;
        waitRdy;
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= d;
        waitRdy;
        rv = hrdata;
    endtask
    task automatic rd(logic [7:0] a);
        bus(1'h0, a, 32'h0);
    endtask
    task automatic trip;
        ocCmp <= 1'h1;
        cyc(10);
        ocCmp <= 1'h0;
    endtask
    task automatic waitPulse(int lim);
        gap = 0;
        pulseLen = 0;
        while (hostResetOutN !== 1'h0 && gap < lim) begin
            cyc(1);
            gap++;
        end
        while (hostResetOutN !== 1'h1 && pulseLen < lim) begin
            cyc(1);
            pulseLen++;
        end
        if (gap >= lim || pulseLen >= lim) begin
            n_fail++;
            results;
        end
    endtask
    task automatic t_regs;
        rd(8'h04);
        chk("pol rst", 32'h2AAAA, rv);
        chk("resp", 1'h0, hresp);
        rd(8'h00);
        chk("ctrl rst", 32'h0, rv);
        bus(1'h1, 8'h04, 32'h0AAAA);
        rd(8'h3C);
        chk("unmapped", 32'h0, rv);
        bus(1'h1, 8'h00, 32'h21F);
        rd(8'h00);
        chk("ctrl", 32'h217, rv);
        chk("gain", 2'h3, senseGainSel);
        chk("offset", 1'h1, senseOffsetSel);
        chk("oc lvl", 2'h2, overcurrentLevelSel);
        chk("th sel", 1'h1, thermalThresholdSel);
    endtask
    task automatic t_mon;
        for (int i = 0; i < 8; i++) begin
            bus(1'h1, 8'h00, {19'h0, i[2:0], 10'h0});
            cyc(2);
            chk("monitor", rt[i], analogMonitorRoute);
        end
    endtask
    task automatic t_oc;
        wantRun <= 1'h1;
        bus(1'h1, 8'h00, 32'h20);
        switchEvt <= 1'h1;
        cyc(2);
        switchEvt <= 1'h0;
        cyc(3);
        ocCmp <= 1'h1;
        cyc(30);
        chk("blank", 1'h0, driverHiZ);
        cyc(100);
        chk("oc hiz", 1'h1, driverHiZ);
        ocCmp <= 1'h0;
        rd(8'h0C);
        chk("oc flag", 32'h20, rv & 32'h20);
        cyc(40);
        chk("auto", 1'h0, driverHiZ);
        bus(1'h1, 8'h04, 32'h0ABAA);
        bus(1'h1, 8'h00, 32'h20020);
        trip;
        cyc(60);
        chk("latch", 1'h1, driverHiZ);
        rd(8'h14);
        chk("latch st", 32'h8, rv & 32'h8);
        bus(1'h1, 8'h08, 32'hFF);
        cyc(4);
        chk("ff clr", 1'h0, driverHiZ);
        trip;
        wantRun <= 1'h0;
        cyc(8);
        wantRun <= 1'h1;
        cyc(8);
        chk("en clr", 1'h0, driverHiZ);
        bus(1'h1, 8'h04, 32'h0A9AA);
        rd(8'h0C);
        ocCmp <= 1'h1;
        cyc(10);
        chk("rep on", 1'h0, driverHiZ);
        chk("rep irq", 1'h0, faultIrqOut);
        ocCmp <= 1'h0;
    endtask
    task automatic t_irq;
        cyc(6);
        rd(8'h0C);
        bus(1'h1, 8'h00, 32'h10000);
        cyc(3);
        chk("irq idle", 1'h0, faultIrqOut);
        supplyUvCmp <= 1'h1;
        cyc(6);
        chk("irq act", 1'h1, faultIrqOut);
        chk("uv off", 1'h1, driverOff);
        supplyUvCmp <= 1'h0;
        rd(8'h0C);
        chk("uv flag", 32'h1, rv & 32'h1);
    endtask
    task automatic t_therm;
        tempWarnCmp <= 1'h1;
        cyc(6);
        rd(8'h10);
        chk("warn", 32'h1, rv & 32'h1);
        tempWarnCmp <= 1'h0;
        tempShutCmp <= 1'h1;
        cyc(6);
        chk("tsd auto", 4'h8, tsdView);
        tempShutCmp <= 1'h0;
        cyc(8);
        bus(1'h1, 8'h04, 32'h029AA);
        tempShutCmp <= 1'h1;
        cyc(6);
        chk("tsd ign", 4'h7, tsdView);
        tempShutCmp <= 1'h0;
        cyc(8);
    endtask
    task automatic t_wd;
        bus(1'h1, 8'h00, 32'h2000);
        bus(1'h1, 8'h04, 32'h2A9AA);
        waitPulse(2000);
        cyc(50);
        bus(1'h1, 8'h08, 32'h0);
        cyc(150);
        bus(1'h1, 8'h08, 32'h0);
        cyc(150);
        bus(1'h1, 8'h08, 32'h0);
        chk("restart", 1'h1, hostResetOutN);
        bus(1'h1, 8'h08, 32'h0);
        waitPulse(60);
        chk("closed", 1'h1, gap < 10);
        chk("pulse", 1'h1, pulseLen >= 50 && pulseLen <= 52);
        rd(8'h10);
        chk("wd flag", 32'h4, rv & 32'h4);
        waitPulse(600);
        chk("expiry", 1'h1, gap >= 390 && gap <= 410);
        regUvCmp <= 1'h1;
        cyc(10);
        chk("reg uv", 2'h2, {driverOff, hostResetOutN});
        regUvCmp <= 1'h0;
        cyc(8);
    endtask
    initial begin
        cyc(5);
        sys_rst <= 1'h0;
        t_regs;
        t_mon;
        t_oc;
        t_irq;
        t_therm;
        t_wd;
        results;
    end
endmodule // fault_supervisor_watchdog_bench
